// File: hdl/tseq_defines.vh
// Register map, field positions, codes and timing of the test-state sequencer
`ifndef TSEQ_DEFINES_VH
`define TSEQ_DEFINES_VH
`define OFS_CTRL      8'h00
`define OFS_STATUS    8'h04
`define OFS_IRQ_STAT  8'h08
`define OFS_IRQ_MASK  8'h0C
`define OFS_TBL_ADDR  8'h10
`define OFS_TBL_DATA  8'h14
`define OFS_RES_ADDR  8'h18
`define OFS_RES_DATA  8'h1C
`define CTRL_START    0
`define CTRL_STOP     1
`define CTRL_NUM_LSB  8
`define NUM_RST       8'h01
`define MASK_RST      3'h0
`define IRQ_STATE_END 0
`define IRQ_TEST_DONE 1
`define IRQ_SENSE     2
`define FN_OPEN_CLOSE 2'h1
`define FN_CLOSE_OPEN 2'h2
`define END_CLOSED    2'h1
`define END_OPEN      2'h2
`define TICK_NS       1000000
`define CLK_NS        20
`define CLK_PER_MS    (`TICK_NS / `CLK_NS)
`define DLY_SAT       8'hFF
`define LAST_WORD     3'h4
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// File: hdl/test_state_sequencer.v
// Relay test-state sequencer with AXI4-Lite registers
//
// The implementer's own choices: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tseq_defines.vh"
module test_state_sequencer #(
   parameter CLK_PER_MS = `CLK_PER_MS
) (
   input  wire        sys_clk,
   input  wire        sys_rst,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [5:0]  sense_in,
   output reg  [9:0]  contact_out,
   output reg         irq
);
   localparam NUM_IN  = 6;
   localparam S_IDLE  = 4'b0001;
   localparam S_LOAD  = 4'b0010;
   localparam S_RUN   = 4'b0100;
   localparam S_STORE = 4'b1000;

   reg  [31:0] tbl_mem [0:2047];
   reg  [31:0] res_mem [0:2047];
   reg  [3:0]  state_q;
   reg  [7:0]  idx_q;
   reg  [8:0]  exec_q;
   reg  [2:0]  wc_q;
   reg  [31:0] tick_cnt_q;
   reg  [23:0] ms_q;
   reg  [23:0] dur_q;
   reg         sel_en_q;
   reg  [7:0]  next_a_q;
   reg  [7:0]  next_b_q;
   reg  [11:0] func_q;
   reg  [11:0] endc_q;
   reg  [47:0] dly_q;
   reg  [5:0]  sel_mask_q;
   reg         early_q;
   reg  [23:0] used_q;
   reg         aw_have_q;
   reg         w_have_q;
   reg  [7:0]  aw_addr_q;
   reg  [31:0] w_data_q;
   reg  [31:0] w_mask_q;
   reg  [7:0]  num_states_q;
   reg  [2:0]  irq_mask_q;
   reg  [2:0]  irq_stat_q;
   reg  [10:0] tbl_addr_q;
   reg  [10:0] res_addr_q;
   reg  [31:0] rd_d;
   reg  [1:0]  rresp_d;
   reg  [31:0] res_word;
   reg  [8:0]  nxt;

   wire [5:0]  hit_w;
   wire [5:0]  sens_w;
   wire [5:0]  sens_set_w;
   wire [95:0] time_w;
   wire        tick   = (tick_cnt_q == CLK_PER_MS - 1);
   wire        load   = state_q[1];
   wire        run    = state_q[2];
   wire        wr_go  = aw_have_q & w_have_q & ~s_axi_bvalid;
   wire        rd_go  = s_axi_arvalid & s_axi_arready;
   wire        wr_ctl = wr_go && aw_addr_q == `OFS_CTRL && w_mask_q[0];
   wire        start  = wr_ctl && w_data_q[`CTRL_START];
   wire        stop   = wr_ctl && w_data_q[`CTRL_STOP];
   wire        st_end = run && (ms_q >= dur_q || |hit_w);
   wire        t_done = state_q[3] && wc_q == `LAST_WORD && nxt >= {1'b0, num_states_q};
   wire [31:0] merged = (w_data_q & w_mask_q);
   wire [2:0]  ev     = {|sens_set_w, t_done, st_end};

   genvar i;
   generate
      for (i = 0; i < NUM_IN; i = i + 1) begin : g_in
         reg        lvl_q;
         reg        acc_q;
         reg        sens_q;
         reg  [7:0] since_q;
         reg [15:0] chg_q;
         reg [15:0] time_q;
         wire [1:0] fn    = func_q[2*i+1:2*i];
         wire [1:0] ec    = endc_q[2*i+1:2*i];
         wire       want  = (fn == `FN_OPEN_CLOSE);
         wire       watch = (fn == `FN_OPEN_CLOSE) || (fn == `FN_CLOSE_OPEN);
         wire       stab  = (sense_in[i] == lvl_q) && (since_q >= dly_q[8*i+7:8*i]);
         wire       cond  = (acc_q == want) || (stab && lvl_q == want);
         assign sens_set_w[i] = run && watch && !sens_q && cond;
         assign hit_w[i] = (ec == `END_CLOSED && acc_q) || (ec == `END_OPEN && !acc_q);
         assign sens_w[i] = sens_q;
         assign time_w[16*i+15:16*i] = time_q;
         always @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
               lvl_q   <= 1'b0;
               acc_q   <= 1'b0;
               sens_q  <= 1'b0;
               since_q <= 8'h00;
               chg_q   <= 16'h0000;
               time_q  <= 16'h0000;
            end else if (load) begin
               // Level at entry is taken as already stable
               lvl_q   <= sense_in[i];
               acc_q   <= sense_in[i];
               sens_q  <= 1'b0;
               since_q <= 8'h00;
               chg_q   <= 16'h0000;
               time_q  <= 16'h0000;
            end else begin
               if (sense_in[i] != lvl_q) begin
                  // Any bounce restarts the stable window
                  lvl_q   <= sense_in[i];
                  since_q <= 8'h00;
                  chg_q   <= ms_q[15:0];
               end else if (tick && since_q != `DLY_SAT) begin
                  since_q <= since_q + 8'h01;
               end
               if (stab)
                  acc_q <= lvl_q;
               if (sens_set_w[i]) begin
                  sens_q <= 1'b1;
                  time_q <= chg_q;
               end
            end
         end
      end
   endgenerate

   always @* begin
      case (wc_q)
         3'h0: res_word = {idx_q, used_q};
         3'h1: res_word = {15'h0000, early_q, 10'h000, sens_w};
         3'h2: res_word = time_w[31:0];
         3'h3: res_word = time_w[63:32];
         default: res_word = time_w[95:64];
      endcase
      if (sel_en_q)
         nxt = (|(sens_w & sel_mask_q)) ? {1'b0, next_a_q} : {1'b0, next_b_q};
      else
         nxt = {1'b0, idx_q} + 9'h001;
   end

   // Sequencer
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_q     <= S_IDLE;
         idx_q       <= 8'h00;
         exec_q      <= 9'h000;
         wc_q        <= 3'h0;
         tick_cnt_q  <= 32'h0000_0000;
         ms_q        <= 24'h00_0000;
         dur_q       <= 24'h00_0000;
         sel_en_q    <= 1'b0;
         next_a_q    <= 8'h00;
         next_b_q    <= 8'h00;
         func_q      <= 12'h000;
         endc_q      <= 12'h000;
         dly_q       <= 48'h0000_0000_0000;
         sel_mask_q  <= 6'h00;
         early_q     <= 1'b0;
         used_q      <= 24'h00_0000;
         contact_out <= 10'h000;
      end else if (stop) begin
         state_q     <= S_IDLE;
         contact_out <= 10'h000;
      end else begin
         if (load || tick)
            tick_cnt_q <= 32'h0000_0000;
         else
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
         case (state_q)
            S_IDLE: begin
               // An empty list never starts
               if (start && num_states_q != 8'h00) begin
                  idx_q   <= 8'h00;
                  exec_q  <= 9'h000;
                  state_q <= S_LOAD;
               end
            end
            S_LOAD: begin
               // All settings latched once, frozen until the next entry
               dur_q       <= tbl_mem[{idx_q, 3'h0}][23:0];
               contact_out <= tbl_mem[{idx_q, 3'h1}][9:0];
               sel_en_q    <= tbl_mem[{idx_q, 3'h1}][15];
               next_a_q    <= tbl_mem[{idx_q, 3'h1}][23:16];
               next_b_q    <= tbl_mem[{idx_q, 3'h1}][31:24];
               func_q      <= tbl_mem[{idx_q, 3'h2}][11:0];
               endc_q      <= tbl_mem[{idx_q, 3'h2}][23:12];
               dly_q       <= {tbl_mem[{idx_q, 3'h4}][15:0], tbl_mem[{idx_q, 3'h3}]};
               sel_mask_q  <= tbl_mem[{idx_q, 3'h4}][21:16];
               ms_q        <= 24'h00_0000;
               state_q     <= S_RUN;
            end
            S_RUN: begin
               if (tick)
                  ms_q <= ms_q + 24'h00_0001;
               if (st_end) begin
                  early_q <= |hit_w;
                  used_q  <= ms_q;
                  wc_q    <= 3'h0;
                  state_q <= S_STORE;
               end
            end
            S_STORE: begin
               // Records past 256 executions are dropped
               if (!exec_q[8])
                  res_mem[{exec_q[7:0], wc_q}] <= res_word;
               wc_q <= wc_q + 3'h1;
               if (wc_q == `LAST_WORD) begin
                  exec_q <= exec_q + {8'h00, !exec_q[8]};
                  if (t_done) begin
                     state_q     <= S_IDLE;
                     contact_out <= 10'h000;
                  end else begin
                     idx_q   <= nxt[7:0];
                     state_q <= S_LOAD;
                  end
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   always @* begin
      rd_d    = 32'h0000_0000;
      rresp_d = `RESP_OKAY;
      case (s_axi_araddr)
         `OFS_CTRL:     rd_d = {16'h0000, num_states_q, 8'h00};
         `OFS_STATUS:   rd_d = {7'h00, exec_q, idx_q, 7'h00, !state_q[0]};
         `OFS_IRQ_STAT: rd_d = {29'h0000_0000, irq_stat_q};
         `OFS_IRQ_MASK: rd_d = {29'h0000_0000, irq_mask_q};
         `OFS_TBL_ADDR: rd_d = {21'h00_0000, tbl_addr_q};
         `OFS_TBL_DATA: rd_d = tbl_mem[tbl_addr_q];
         `OFS_RES_ADDR: rd_d = {21'h00_0000, res_addr_q};
         `OFS_RES_DATA: rd_d = res_mem[res_addr_q];
         default:       rresp_d = `RESP_SLVERR;
      endcase
   end

   // Bus slave, register file and interrupt
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `RESP_OKAY;
         aw_have_q     <= 1'b0;
         w_have_q      <= 1'b0;
         aw_addr_q     <= 8'h00;
         w_data_q      <= 32'h0000_0000;
         w_mask_q      <= 32'h0000_0000;
         num_states_q  <= `NUM_RST;
         irq_mask_q    <= `MASK_RST;
         irq_stat_q    <= 3'h0;
         tbl_addr_q    <= 11'h000;
         res_addr_q    <= 11'h000;
         irq           <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q     <= 1'b1;
            aw_addr_q     <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q     <= 1'b1;
            w_data_q     <= s_axi_wdata;
            w_mask_q     <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                             {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_have_q    <= 1'b0;
            w_have_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `RESP_OKAY;
            case (aw_addr_q)
               `OFS_CTRL: begin
                  if (w_mask_q[8])
                     num_states_q <= w_data_q[15:8];
               end
               `OFS_IRQ_MASK: begin
                  if (w_mask_q[0])
                     irq_mask_q <= w_data_q[2:0];
               end
               `OFS_TBL_ADDR: begin
                  tbl_addr_q <= (tbl_addr_q & ~w_mask_q[10:0]) | merged[10:0];
               end
               `OFS_TBL_DATA: begin
                  // Auto-increment lets a state list stream in
                  tbl_mem[tbl_addr_q] <= (tbl_mem[tbl_addr_q] & ~w_mask_q) | merged;
                  tbl_addr_q          <= tbl_addr_q + 11'h001;
               end
               `OFS_RES_ADDR: begin
                  res_addr_q <= (res_addr_q & ~w_mask_q[10:0]) | merged[10:0];
               end
               `OFS_STATUS, `OFS_IRQ_STAT, `OFS_RES_DATA: s_axi_bresp <= `RESP_OKAY;
               default: s_axi_bresp <= `RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
         if (rd_go) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_d;
            s_axi_rresp   <= rresp_d;
            if (s_axi_araddr == `OFS_RES_DATA)
               res_addr_q <= res_addr_q + 11'h001;
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
         // A new event in the clearing cycle survives the clear
         if (rd_go && s_axi_araddr == `OFS_IRQ_STAT)
            irq_stat_q <= ev;
         else
            irq_stat_q <= irq_stat_q | ev;
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end
endmodule

// File: testbench/tseq_checker.sv
// Port-level assertions for the test-state sequencer
`timescale 1ns/1ps
`include "tseq_defines.vh"
module tseq_checker (
   input wire        sys_clk,
   input wire        sys_rst,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [9:0]  contact_out
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence wr_answer;
      !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
   endsequence
   AST_WR_TIMING:
      assert property (wr_taken |=> wr_answer) else $error("write answer late");
   AST_B_HOLD:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_B_DONE:
      assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready
         && s_axi_wready) else $error("write channel not freed");
   AST_RD_TIMING:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   AST_R_HOLD:
      assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_R_DONE:
      assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel not freed");
   AST_R_ERR:
      assert property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == '0)
      else $error("refused read carries data");
   // Stop may follow a load, but contacts must first hold for two cycles
   AST_STATE_HOLD:
      assert property ($changed(contact_out) |=> $stable(contact_out) [*2])
      else $error("contacts changed inside a state");
endmodule
bind test_state_sequencer tseq_checker u_tseq_checker (
   .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .contact_out(contact_out));

// File: testbench/relay_model.sv
// Relay under test: delayed trip contact and a chattering contact
`timescale 1ns/1ps
module relay_model #(
   parameter TRIP = 40
) (
   input  wire        sys_clk,
   input  wire [9:0]  contact_out,
   output wire [5:0]  sense_in
);
   int cnt0 = 0;
   int cnt1 = 0;
   always @(posedge sys_clk) begin
      cnt0 <= contact_out[0] ? cnt0 + 1 : 0;
      cnt1 <= contact_out[1] ? cnt1 + 1 : 0;
   end
   // Chatter is five cycles, shorter than any filter of two ticks or more
   assign sense_in[0] = (cnt0 >= TRIP);
   assign sense_in[1] = (cnt1 >= 20 && cnt1 < 25);
   assign sense_in[5:2] = contact_out[5:2];
endmodule

// File: testbench/tb_top.sv
// Register-level regression of the test-state sequencer
`timescale 1ns/1ps
`include "tseq_defines.vh"
module tb_top;
   logic        sys_clk = 0;
   logic        sys_rst = 1;
   logic [7:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rd;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   wire         awready, wready, bvalid, arready, rvalid, irq;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [5:0]  sense_in;
   wire  [9:0]  contact_out;
   int          errors = 0, num_checks = 0, cyc = 0, el;
   always #10 sys_clk = ~sys_clk;
   test_state_sequencer #(.CLK_PER_MS(10)) u_test_state_sequencer (
      .sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sense_in(sense_in), .contact_out(contact_out), .irq(irq));
   relay_model u_relay_model (.sys_clk(sys_clk), .contact_out(contact_out), .sense_in(sense_in));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      logic aw, w;
      aw = 0;
      w = 0;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      while (!(aw && w)) begin
         @(posedge sys_clk);
         if (awready && !aw) begin
            aw = 1;
            awvalid <= 0;
         end
         if (wready && !w) begin
            w = 1;
            wvalid <= 0;
         end
      end
      do @(posedge sys_clk); while (!bvalid);
      bready <= 0;
      chk(bresp, er, "bresp");
      @(posedge sys_clk);
   endtask
   task automatic rdr(input logic [7:0] a, input logic [1:0] er = 2'h0);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do @(posedge sys_clk); while (!arready);
      arvalid <= 0;
      do @(posedge sys_clk); while (!rvalid);
      rready <= 0;
      rd = rdata;
      chk(rresp, er, "rresp");
      @(posedge sys_clk);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] exp, input string m);
      rdr(a);
      chk(rd, exp, m);
   endtask
   task automatic ld(input logic [7:0] s, input logic [31:0] w[5]);
      wr(`OFS_TBL_ADDR, {21'h0, s, 3'h0});
      foreach (w[i]) wr(`OFS_TBL_DATA, w[i]);
   endtask
   task automatic idle();
      do rdr(`OFS_STATUS); while (rd[0] !== 1'b0);
   endtask
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Whole run needs a few hundred cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         $display("MISMATCH t=%0t timeout", $time);
         summarize();
      end
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 0;
      @(posedge sys_clk);
      rc(`OFS_CTRL, 32'h0000_0100, "ctrl");
      rc(`OFS_STATUS, '0, "status");
      rc(`OFS_IRQ_MASK, '0, "mask");
      rc(`OFS_TBL_ADDR, '0, "tbl");
      rc(`OFS_RES_ADDR, '0, "res");
      rdr(8'h20, `RESP_SLVERR);
      wr(8'h20, 32'hFFFF_FFFF, `RESP_SLVERR);
      wr(`OFS_STATUS, 32'hFFFF_FFFF);
      rc(`OFS_STATUS, '0, "status ro");
      $display("test regs done");
      ld(8'h00, '{32'h0000_0003, 32'h0000_02A5, '0, '0, '0});
      wr(`OFS_IRQ_MASK, 32'h0000_0002);
      wr(`OFS_CTRL, 32'h0000_0101);
      chk(contact_out, 32'h0000_02A5, "contacts");
      idle();
      chk(contact_out, '0, "idle contacts");
      chk(irq, 1, "irq done");
      rc(`OFS_IRQ_STAT, 32'h0000_0003, "irq stat");
      chk(irq, 0, "irq cleared");
      wr(`OFS_RES_ADDR, '0);
      rc(`OFS_RES_DATA, 32'h0000_0003, "elapsed");
      rc(`OFS_RES_DATA, '0, "not early");
      $display("test duration done");
      ld(8'h00, '{32'h0000_0032, 32'h0102_8001, 32'h0000_1001, 32'h0000_0002, 32'h0001_0000});
      ld(8'h01, '{32'h0000_0001, 32'h0000_03FF, '0, '0, '0});
      ld(8'h02, '{32'h0000_0008, 32'h0000_0002, 32'h0000_4004, 32'h0000_0200, '0});
      wr(`OFS_CTRL, 32'h0000_0301);
      idle();
      chk(rd[24:16], 32'h0000_0002, "exec count");
      rc(`OFS_IRQ_STAT, 32'h0000_0007, "irq events");
      wr(`OFS_RES_ADDR, '0);
      rdr(`OFS_RES_DATA);
      el = rd[23:0];
      chk(rd[31:24], '0, "first idx");
      chk(el < 50 && el >= 6, 1, "early end");
      rc(`OFS_RES_DATA, 32'h0001_0001, "sensed");
      rdr(`OFS_RES_DATA);
      chk(rd[15:0] >= 3 && rd[15:0] <= 5, 1, "stamp");
      wr(`OFS_RES_ADDR, 32'h0000_0008);
      rc(`OFS_RES_DATA, 32'h0200_0008, "second");
      rc(`OFS_RES_DATA, '0, "glitch gone");
      $display("test select done");
      ld(8'h00, '{32'h0000_0001, 32'h0000_8010, '0, '0, '0});
      wr(`OFS_IRQ_MASK, 32'h0000_0001);
      wr(`OFS_CTRL, 32'h0000_0101);
      repeat (100) @(posedge sys_clk);
      chk(irq, 1, "irq state end");
      chk(contact_out, 32'h0000_0010, "repeat contacts");
      rdr(`OFS_STATUS);
      chk(rd[0] && rd[24:16] > 3, 1, "repeating");
      wr(`OFS_IRQ_MASK, '0);
      chk(irq, 0, "irq masked");
      wr(`OFS_CTRL, 32'h0000_0102);
      chk(contact_out, '0, "stopped");
      $display("test repeat done");
      ld(8'h00, '{32'h0000_0010, '0, 32'h0002_0020, 32'h0005_0000, '0});
      wr(`OFS_CTRL, 32'h0000_0101);
      idle();
      wr(`OFS_RES_ADDR, '0);
      rc(`OFS_RES_DATA, '0, "ended at entry");
      rc(`OFS_RES_DATA, 32'h0001_0004, "open at entry");
      rc(`OFS_RES_DATA, '0, "stamp t1 t0");
      rc(`OFS_RES_DATA, '0, "entry stamp");
      $display("test entry done");
      summarize();
   end
endmodule
